// ### rtl/pcrs_sequencer.sv
`timescale 1ns/1ps
`include "pcrs_map.svh"
module pcrs_sequencer import pcrs_pkg::*; #(
	parameter int settle_cyc = `PCRS_SETTLE_CYC,
	parameter int wake_cyc = `PCRS_WAKE_CYC
) (
	// clock and reset
	input wire logic clock,
	input wire logic resetn,
	// reset sources and oscillator/flash status (async pins)
	input wire logic reset_pin_n,
	input wire logic watchdog_reset,
	input wire logic osc_running,
	input wire logic flash_init_done,
	// power-down control from logic on this clock
	input wire logic power_down_req,
	input wire logic wake_event,
	// pll configuration
	input wire pcrs_cfg_type cfg,
	// status and clock controls
	output pcrs_stat_type status,
	output logic osc_enable,
	output logic clock_gate_en,
	output logic pll_run,
	output logic [5:0] pll_mult,
	output pcrs_div_type pll_div
);
	typedef struct packed {
		pcrs_wake_type st;
		logic [1:0] osc_sync;
		logic [1:0] flash_sync;
		logic [1:0] wdt_sync;
		logic pd;
		logic [31:0] wake_cnt;
		logic [31:0] settle_cnt;
		logic pll_en;
		logic lock;
		logic conn;
		logic [5:0] mult;
		pcrs_div_type div;
		pcrs_stat_type stat;
		logic osc_en;
		logic gate;
	} pcrs_seq_type;
	pcrs_seq_type s_r, s_nxt;
	logic pin_n_filt;
	logic chip_reset;
	// ----------------------------------------
	// reset pin glitch filter
	// ----------------------------------------
	pcrs_filter #(
		.width(4),
		.count(4'(`PCRS_GLITCH_CYC))
	) u_filter (
		.clock(clock),
		.resetn(resetn),
		.level_in(reset_pin_n),
		.level_out(pin_n_filt)
	);
	// ----------------------------------------
	// next-state logic
	// ----------------------------------------
	always_comb begin
		// ----------------------------------------
		// reset sources and input synchronisers
		// ----------------------------------------
		// pin goes through the filter; the rest are plain two-stage syncs
		chip_reset = !pin_n_filt || s_r.wdt_sync[1];
		s_nxt = s_r;
		s_nxt.osc_sync = {s_r.osc_sync[0], osc_running};
		s_nxt.flash_sync = {s_r.flash_sync[0], flash_init_done};
		s_nxt.wdt_sync = {s_r.wdt_sync[0], watchdog_reset};
		// ----------------------------------------
		// wake-up timer
		// ----------------------------------------
		case (s_r.st)
			pcrs_st_hold: begin
				s_nxt.wake_cnt = '0;
				s_nxt.osc_en = 1'b1;
				if (!chip_reset) begin
					s_nxt.st = pcrs_st_wait_osc;
				end
			end
			pcrs_st_wait_osc: begin
				if (s_r.osc_sync[1]) begin
					s_nxt.st = pcrs_st_count;
				end
			end
			pcrs_st_count: begin
				// counts oscillator-derived clocks once it runs
				if (!s_r.osc_sync[1]) begin
					s_nxt.st = pcrs_st_wait_osc;
					s_nxt.wake_cnt = '0;
				end else if (s_r.wake_cnt == 32'(wake_cyc - 1)) begin
					if (s_r.flash_sync[1] || s_r.pd) begin
						s_nxt.st = pcrs_st_run;
						s_nxt.gate = 1'b1;
						s_nxt.pd = 1'b0;
						// a power-down wake leaves the chip out of reset
						if (!s_r.pd) begin
							s_nxt.stat.sys_reset_n = 1'b1;
						end
					end
				end else begin
					s_nxt.wake_cnt = s_r.wake_cnt + 32'h00000001;
				end
			end
			pcrs_st_run: begin
				if (power_down_req) begin
					// clocks off, state kept
					s_nxt.osc_en = 1'b0;
					s_nxt.gate = 1'b0;
					s_nxt.pd = 1'b1;
					s_nxt.st = pcrs_st_hold;
				end
			end
			default: s_nxt.st = pcrs_st_hold;
		endcase
		// ----------------------------------------
		// power-down wake re-enters the timer
		// ----------------------------------------
		if (s_r.pd && s_r.st == pcrs_st_hold) begin
			s_nxt.osc_en = 1'b0;
			s_nxt.st = pcrs_st_hold;
			if (wake_event || chip_reset) begin
				s_nxt.osc_en = 1'b1;
				s_nxt.st = pcrs_st_wait_osc;
			end
		end
		// ----------------------------------------
		// pll configuration
		// ----------------------------------------
		// ignored in reset, so the pll stays bypassed until software acts
		if (s_r.stat.sys_reset_n) begin
			s_nxt.pll_en = cfg.enable;
			// zero would stall the loop, so it reads as one
			if (cfg.mult < `PCRS_MULT_MIN) begin
				s_nxt.mult = `PCRS_MULT_MIN;
			end else if (cfg.mult > `PCRS_MULT_MAX) begin
				s_nxt.mult = `PCRS_MULT_MAX;
			end else begin
				s_nxt.mult = cfg.mult;
			end
			s_nxt.div = cfg.div;
			s_nxt.conn = cfg.connect;
		end
		// ----------------------------------------
		// pll settling and lock
		// ----------------------------------------
		// any multiplier or divider change restarts the settle count
		if (!s_r.pll_en || s_r.mult != s_nxt.mult || s_r.div != s_nxt.div
				|| s_r.pd) begin
			s_nxt.settle_cnt = '0;
			s_nxt.lock = 1'b0;
		end else if (s_r.settle_cnt == 32'(settle_cyc - 1)) begin
			s_nxt.lock = 1'b1;
		end else begin
			s_nxt.settle_cnt = s_r.settle_cnt + 32'h00000001;
		end
		s_nxt.stat.pll_lock = s_nxt.lock;
		// ----------------------------------------
		// status
		// ----------------------------------------
		// pll output used only when running and connected
		s_nxt.stat.pll_connected = s_nxt.pll_en && s_nxt.conn;
		s_nxt.stat.fetch_addr = `PCRS_RESET_VECTOR;
		// ----------------------------------------
		// chip reset override
		// ----------------------------------------
		// chip reset wins: defaults restored, pll off and bypassed
		if (chip_reset) begin
			s_nxt.st = pcrs_st_hold;
			s_nxt.pd = 1'b0;
			s_nxt.gate = 1'b0;
			s_nxt.osc_en = 1'b1;
			s_nxt.stat.sys_reset_n = 1'b0;
			s_nxt.pll_en = `PCRS_RST_PLL_EN;
			s_nxt.conn = `PCRS_RST_PLL_CONN;
			s_nxt.lock = 1'b0;
			s_nxt.stat.pll_lock = 1'b0;
			s_nxt.stat.pll_connected = 1'b0;
			s_nxt.mult = `PCRS_MULT_MIN;
			s_nxt.div = pcrs_div2_type_v;
		end
	end
	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			// every field named so reset values stay explicit
			s_r.st <= pcrs_st_hold;
			s_r.osc_sync <= 2'h0;
			s_r.flash_sync <= 2'h0;
			s_r.wdt_sync <= 2'h0;
			s_r.pd <= 1'b0;
			s_r.wake_cnt <= 32'h00000000;
			s_r.settle_cnt <= 32'h00000000;
			s_r.pll_en <= `PCRS_RST_PLL_EN;
			s_r.lock <= 1'b0;
			s_r.conn <= `PCRS_RST_PLL_CONN;
			s_r.mult <= `PCRS_MULT_MIN;
			s_r.div <= pcrs_div2_type_v;
			s_r.stat.pll_lock <= 1'b0;
			s_r.stat.pll_connected <= 1'b0;
			s_r.stat.sys_reset_n <= 1'b0;
			s_r.stat.fetch_addr <= `PCRS_RESET_VECTOR;
			s_r.osc_en <= 1'b1;
			s_r.gate <= 1'b0;
		end else begin
			s_r <= s_nxt;
		end
	end
	// ----------------------------------------
	// outputs
	// ----------------------------------------
	// all outputs come straight from the state register
	assign status = s_r.stat;
	assign osc_enable = s_r.osc_en;
	assign clock_gate_en = s_r.gate;
	assign pll_run = s_r.pll_en;
	assign pll_mult = s_r.mult;
	assign pll_div = s_r.div;
endmodule : pcrs_sequencer

// ### rtl/pcrs_map.svh
`ifndef PCRS_MAP_SVH
`define PCRS_MAP_SVH
`define PCRS_CLK_MHZ 125
`define PCRS_SETTLE_US 100
`define PCRS_SETTLE_CYC (`PCRS_SETTLE_US * `PCRS_CLK_MHZ)
`define PCRS_MULT_MIN 6'h01
`define PCRS_MULT_MAX 6'h20
`define PCRS_GLITCH_CYC 8
`define PCRS_WAKE_CYC 4096
`define PCRS_RESET_VECTOR 32'h00000000
`define PCRS_RST_PLL_EN 1'b0
`define PCRS_RST_PLL_CONN 1'b0
`endif

// ### rtl/pcrs_pkg.sv
package pcrs_pkg;
	typedef enum logic [1:0] {
		pcrs_div2_type_v = 2'b00,
		pcrs_div4_type_v = 2'b01,
		pcrs_div8_type_v = 2'b10,
		pcrs_div16_type_v = 2'b11
	} pcrs_div_type;
	typedef enum logic [1:0] {
		pcrs_st_hold = 2'b00,
		pcrs_st_wait_osc = 2'b01,
		pcrs_st_count = 2'b10,
		pcrs_st_run = 2'b11
	} pcrs_wake_type;
	typedef struct packed {
		logic enable;
		logic connect;
		logic [5:0] mult;
		pcrs_div_type div;
	} pcrs_cfg_type;
	typedef struct packed {
		logic pll_lock;
		logic pll_connected;
		logic sys_reset_n;
		logic [31:0] fetch_addr;
	} pcrs_stat_type;
endpackage : pcrs_pkg

// ### rtl/pcrs_filter.sv
`timescale 1ns/1ps
module pcrs_filter import pcrs_pkg::*; #(
	parameter int width = 4,
	parameter logic [width-1:0] count = 4'h8
) (
	// clock and reset
	input wire logic clock,
	input wire logic resetn,
	// level in and filtered level out
	input wire logic level_in,
	output logic level_out
);
	typedef struct packed {
		logic [1:0] sync;
		logic [width-1:0] cnt;
		logic out;
	} pcrs_filt_type;
	pcrs_filt_type s_r, s_nxt;
	// ----------------------------------------
	// two-stage sync then stability counter
	// ----------------------------------------
	always_comb begin
		s_nxt = s_r;
		s_nxt.sync = {s_r.sync[0], level_in};
		if (s_r.sync[1] == s_r.out) begin
			s_nxt.cnt = '0;
		end else if (s_r.cnt == count - 1'b1) begin
			s_nxt.out = s_r.sync[1];
			s_nxt.cnt = '0;
		end else begin
			s_nxt.cnt = s_r.cnt + 1'b1;
		end
	end
	// starts in the asserted (low) state
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end
	assign level_out = s_r.out;
endmodule : pcrs_filter

// ### bench/pcrs_sequencer_chk.sv
`timescale 1ns/1ps
// --
// sequencer checker
// --
module pcrs_sequencer_chk import pcrs_pkg::*; #(
	parameter int settle_cyc = 20,
	parameter int wake_cyc = 16
) (
	// watched inputs
	input wire logic clock,
	input wire logic resetn,
	input wire logic reset_pin_n,
	input wire logic watchdog_reset,
	input wire logic osc_running,
	input wire logic flash_init_done,
	input wire logic power_down_req,
	input wire logic wake_event,
	input wire pcrs_cfg_type cfg,
	// watched outputs
	input wire pcrs_stat_type status,
	input wire logic osc_enable,
	input wire logic clock_gate_en,
	input wire logic pll_run,
	input wire logic [5:0] pll_mult,
	input wire pcrs_div_type pll_div
);
	int run_cnt;
	int osc_cnt;
	logic [7:0] md_q;
	// settings change restarts the settle count
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			run_cnt <= 0;
			osc_cnt <= 0;
			md_q <= 8'h00;
		end else begin
			md_q <= {pll_mult, pll_div};
			run_cnt <= (pll_run && {pll_mult, pll_div} == md_q) ? run_cnt + 1 : 0;
			osc_cnt <= osc_running ? osc_cnt + 1 : 0;
		end
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	pll_off_reset_a:
	assert property (!status.sys_reset_n [*2] |-> !pll_run &&
		!status.pll_connected) else $error("pll alive in reset");
	mult_range_a:
	assert property (pll_mult >= 6'h01 && pll_mult <= 6'h20)
		else $error("multiplier out of range");
	clock_source_a:
	assert property (status.pll_connected |-> pll_run)
		else $error("connected while pll off");
	lock_settle_a:
	assert property ($rose(status.pll_lock) |-> pll_run &&
		run_cnt >= settle_cyc - 2) else $error("lock too early");
	release_order_a:
	assert property ($rose(status.sys_reset_n) |-> status.fetch_addr == 32'h0
		&& $past(reset_pin_n, 2) && $past(flash_init_done, 3))
		else $error("reset released too early");
	wake_timer_a:
	assert property ($rose(clock_gate_en) |-> osc_cnt >= wake_cyc)
		else $error("clocks before wake count");
	power_down_a:
	assert property (power_down_req && status.sys_reset_n && clock_gate_en
		|=> !osc_enable && !clock_gate_en) else $error("power-down ignored");
	watchdog_rst_a:
	assert property ($rose(watchdog_reset) |-> ##[1:6] !status.sys_reset_n)
		else $error("watchdog reset missed");
endmodule : pcrs_sequencer_chk
bind pcrs_sequencer pcrs_sequencer_chk #(.settle_cyc(settle_cyc),
	.wake_cyc(wake_cyc)) chk_u (.clock, .resetn, .reset_pin_n,
	.watchdog_reset, .osc_running, .flash_init_done, .power_down_req,
	.wake_event, .cfg, .status, .osc_enable, .clock_gate_en, .pll_run,
	.pll_mult, .pll_div);

// ### bench/pcrs_xtal.sv
`timescale 1ns/1ps
// --
// crystal oscillator model
// --
module pcrs_xtal #(
	parameter int start_cyc = 5
) (
	// clock and enable
	input wire logic clock,
	input wire logic osc_enable,
	// running indication
	output logic osc_running
);
	int cnt = 0;
	initial osc_running = 1'b0;
	// slow start, so the timer never sees a ready oscillator at once
	always @(posedge clock) begin
		cnt <= osc_enable ? cnt + 1 : 0;
		osc_running <= osc_enable && cnt >= start_cyc;
	end
endmodule : pcrs_xtal

// ### bench/tb_top.sv
`timescale 1ns/1ps
// --
// sequencer bench
// --
module tb_top import pcrs_pkg::*;;
	localparam int settle = 20;
	localparam int wake = 16;
	localparam int ref_mhz = 10;
	logic clock = 1'b0;
	logic resetn = 1'b0;
	logic pin_n = 1'b1;
	logic wd = 1'b0;
	logic flash = 1'b1;
	logic pd = 1'b0;
	logic wk = 1'b0;
	logic osc, oe, cg, run;
	logic [5:0] mult;
	pcrs_div_type div;
	pcrs_cfg_type cfg = '0;
	pcrs_stat_type st;
	int error_cnt = 0;
	int compares = 0;
	int n, m;
	int q[$] = '{0, 1, 32, 33, 63};
	always #4 clock = ~clock;
	pcrs_xtal xtal_u (.clock(clock), .osc_enable(oe), .osc_running(osc));
	pcrs_sequencer #(.settle_cyc(settle), .wake_cyc(wake)) dut_u (
		.clock(clock), .resetn(resetn), .reset_pin_n(pin_n),
		.watchdog_reset(wd), .osc_running(osc), .flash_init_done(flash),
		.power_down_req(pd), .wake_event(wk), .cfg(cfg), .status(st),
		.osc_enable(oe), .clock_gate_en(cg), .pll_run(run), .pll_mult(mult),
		.pll_div(div));
	task automatic chk(logic [31:0] got, logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("FAIL %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wt(int sel, int lo);
		n = 0;
		while ((sel ? cg : st.sys_reset_n) !== 1'b1 && n < 300) begin
			@(negedge clock);
			n++;
		end
		chk(n >= lo && n < 300, 1);
	endtask : wt
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : wrap_up
	initial begin
		#20000;
		error_cnt++;
		wrap_up();
	end
	initial begin
		void'($urandom(32'h8ee0c8e8));
		repeat (8) @(negedge clock);
		resetn = 1'b1;
		wt(0, wake);
		chk({run, st.pll_connected}, 2'b00);
		chk(st.fetch_addr, 32'h00000000);
		q.push_front($urandom_range(63));
		foreach (q[i]) begin
			m = i % 4;
			cfg = '{1'b1, 1'b0, q[i][5:0], pcrs_div_type'(m)};
			repeat (3) @(negedge clock);
			chk(mult, q[i] == 0 ? 1 : q[i] > 32 ? 32 : q[i]);
			chk(div, m);
		end
		cfg.mult = 6'h06;
		cfg.div = pcrs_div4_type_v;
		n = 0;
		while (st.pll_lock !== 1'b1 && n < 300) begin
			@(negedge clock);
			n++;
		end
		chk(n >= settle && n <= settle + 5, 1);
		cfg.connect = 1'b1;
		repeat (3) @(negedge clock);
		chk({run, st.pll_connected}, 2'b11);
		chk(ref_mhz * mult, 60);
		chk((ref_mhz * mult) << (div + 1), 240);
		pin_n = 1'b0;
		repeat (5) @(negedge clock);
		pin_n = 1'b1;
		repeat (20) @(negedge clock);
		chk(st.sys_reset_n, 1);
		pin_n = 1'b0;
		flash = 1'b0;
		repeat (14) @(negedge clock);
		chk({st.sys_reset_n, run, st.pll_connected}, 0);
		pin_n = 1'b1;
		repeat (40) @(negedge clock);
		chk(st.sys_reset_n, 0);
		flash = 1'b1;
		wt(0, 1);
		chk(st.fetch_addr, 32'h0);
		wd = 1'b1;
		repeat (2) @(negedge clock);
		wd = 1'b0;
		repeat (4) @(negedge clock);
		chk(st.sys_reset_n, 0);
		wt(0, 1);
		pd = 1'b1;
		@(negedge clock);
		pd = 1'b0;
		@(negedge clock);
		chk({oe, cg}, 0);
		wk = 1'b1;
		@(negedge clock);
		wk = 1'b0;
		wt(1, wake);
		chk({oe, st.sys_reset_n}, 2'b11);
		wrap_up();
	end
endmodule : tb_top
